// [core/jtl_tx_link.sv]
// Transmit link interface: lane framing for 8B/10B and 64B/66B coding.
// Assumes pins already differential-received; 8b/10b and serialisers downstream.
// Notes on behaviour
// - Lanes use either 8B/10B character coding or 64B/66B block coding.
// - 8B/10B output stays usable by older-generation receivers.
// - Data is spread over at most eight lanes.
// - 64B/66B alignment comes from each block's sync header, no handshake.
// - Receiver drives sync low to request character synchronisation.
// - 64B/66B ignores the sync pin except for oscillator sync.
// - Captured SYSREF resets the multiframe or extended multiblock counter.
// - One device clock runs logic and serialisers.
// - Forward error correction is optional in 64B/66B mode.
// - No 64B/80B layer, command channel or CRC3 is produced.
// - Subclass 1 only, output still accepted by subclass-0 receivers.
// - Lanes of one link align; no multipoint reference alignment.
// - Physical sync input with timing compatible with older receivers.
// - While sync is low in 8B/10B, every lane sends K28.5.
// - After sync rises, wait for multiframe edge, send four alignment multiframes.
// - Scrambling always on in 64B/66B, optional in 8B/10B.
`timescale 1ns/1ns
module jtl_tx_link
#(
  parameter int LANES = jtl_pkg::LANE_MAX
) (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic                          enable,
  input  wire logic                          linkEnable,
  input  wire jtl_pkg::jtl_code_t            codeMode,
  input  wire logic                          scrambleEnable,
  input  wire logic                          fecEnable,
  input  wire logic                          syncForNco,
  input  wire logic [jtl_pkg::MF_LEN_W-1:0]  multiframeLen,
  input  wire logic                          sync_request_input_pin,
  input  wire logic                          sysrefPin,
  input  wire logic [LANES*jtl_pkg::OCTET_W-1:0] sampleData,
  input  wire logic                          sampleValid,
  output logic                               sampleReady,
  output logic [LANES*jtl_pkg::OCTET_W-1:0]  laneData,
  output logic [LANES-1:0]                   laneCharK,
  output logic [1:0]                         laneSyncHdr,
  output logic                               laneFecOn,
  output logic                               linkUp,
  output logic                               ncoSync
);
  import jtl_pkg::*;
  localparam int DW = LANES * OCTET_W;

  // All checks below run on the device clock and sleep through reset
  default clocking cbDev @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic [1:0]   pinsSync;
  logic         syncLvl, sysrefLvl;
  logic         syncPrev_reg, sysrefPrev_reg;
  logic         syncPrev_next, sysrefPrev_next;
  logic [MF_LEN_W-1:0] mfCnt_reg, mfCnt_next;
  logic         mfEdge, sysrefRise;
  jtl_state_t   state_reg, state_next;
  logic [2:0]   ilasCnt_reg, ilasCnt_next;
  logic [14:0]  scr8_reg, scr8_next;
  logic [57:0]  scr64_reg, scr64_next;
  logic [DW-1:0] laneData_reg, laneData_next;
  logic [LANES-1:0] laneK_reg, laneK_next;
  logic [1:0]   hdr_reg, hdr_next;
  logic         fec_reg, fec_next, up_reg, up_next, nco_reg, nco_next;
  logic [DW-1:0] fifoData;
  logic         fifoValid, fifoReady, sendData;
  logic [DW-1:0] scrWord;

  // Both asynchronous pins cross through two flip-flops first
  jtl_sync_in #(.WIDTH(2)) uSync (
    .clock   (clock),
    .reset_n (reset_n),
    .enable  (enable),
    .pinIn   ({sysrefPin, sync_request_input_pin}),
    .syncOut (pinsSync)
  );
  assign syncLvl   = pinsSync[0];
  assign sysrefLvl = pinsSync[1];

  // Sample buffer; back-pressure reaches the converter side through sampleReady
  jtl_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) uFifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .enable   (enable),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoReady)
  );

  // Multiframe / extended multiblock counter, zeroed on SYSREF rise
  always_comb begin
    syncPrev_next   = syncLvl;
    sysrefPrev_next = sysrefLvl;
    sysrefRise      = sysrefLvl && !sysrefPrev_reg;
    mfEdge          = (mfCnt_reg == '0);
    if (sysrefRise) begin
      mfCnt_next = '0;
    end else if (mfCnt_reg >= multiframeLen - 1'b1) begin
      mfCnt_next = '0;
    end else begin
      mfCnt_next = mfCnt_reg + 1'b1;
    end
  end

  // Link state: handshake only in 8B/10B
  always_comb begin
    state_next   = state_reg;
    ilasCnt_next = ilasCnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (linkEnable) begin
          state_next = (codeMode == CODE_64B66B) ? ST_RUN : ST_CGS;
        end
      end
      ST_CGS: begin
        // Rising edge of the synced request ends comma phase
        if (syncLvl && !syncPrev_reg) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!syncLvl) begin
          state_next = ST_CGS;
        end else if (mfEdge && ilasCnt_reg == 3'(ILAS_MF)) begin
          state_next = ST_RUN;
        end else if (mfEdge) begin
          ilasCnt_next = ilasCnt_reg + 1'b1;
        end
      end
      ST_RUN: begin
        // Low request in 8B/10B restarts the handshake; ignored in 64B/66B
        if (codeMode == CODE_8B10B && !syncLvl) begin
          state_next = ST_CGS;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!linkEnable) begin
      state_next = ST_IDLE;
    end
    if (state_next == ST_CGS) begin
      ilasCnt_next = '0;
    end
  end

  // Scrambler words; 64B/66B always scrambles, 8B/10B only on request
  always_comb begin
    scr8_next  = scr8_reg;
    scr64_next = scr64_reg;
    scrWord    = fifoData;
    sendData   = (state_reg == ST_RUN) && fifoValid;
    if (sendData && codeMode == CODE_64B66B) begin
      scrWord    = fifoData ^ DW'({scr64_reg, scr64_reg[57:52]});
      scr64_next = {scr64_reg[56:0], scr64_reg[57] ^ scr64_reg[38]};
    end else if (sendData && scrambleEnable) begin
      scrWord    = fifoData ^ DW'({4{scr8_reg}});
      scr8_next  = {scr8_reg[13:0], scr8_reg[14] ^ scr8_reg[13]};
    end
  end
  assign fifoReady = (state_reg == ST_RUN);

  // Lane outputs; same character on every lane keeps one link aligned
  always_comb begin
    laneData_next = '0;
    laneK_next    = '0;
    hdr_next      = SYNC_HDR_DATA; // Every block carries its header
    fec_next      = fecEnable && (codeMode == CODE_64B66B);
    up_next       = (state_next == ST_RUN);
    nco_next      = syncForNco && (codeMode == CODE_64B66B) && !syncLvl;
    case (state_reg)
      ST_CGS: begin
        laneData_next = {LANES{CHAR_K28_5}};
        laneK_next    = '1;
      end
      ST_WAIT: begin
        // Alignment is sent plain: R at start, A at end of multiframe
        if (ilasCnt_reg == '0) begin
          laneData_next = {LANES{CHAR_K28_5}};
          laneK_next    = '1;
        end else if (mfEdge) begin
          laneData_next = {LANES{CHAR_K28_3}};
          laneK_next    = '1;
        end else if (mfCnt_reg == MF_LEN_W'(1)) begin
          laneData_next = {LANES{CHAR_K28_0}};
          laneK_next    = '1;
        end
      end
      ST_RUN: begin
        if (sendData) begin
          laneData_next = scrWord;
        end
      end
      default: laneData_next = '0;
    endcase
    if (codeMode == CODE_8B10B) begin
      hdr_next = '0;
      fec_next = 1'b0;
    end
  end

  // All state registered on the single device clock, frozen by enable
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      syncPrev_reg   <= 1'b1;
      sysrefPrev_reg <= 1'b1; // Synchroniser leaves reset high; avoids a false edge
      mfCnt_reg      <= '0;
      state_reg      <= ST_IDLE;
      ilasCnt_reg    <= '0;
      scr8_reg       <= SCR8_SEED;
      scr64_reg      <= SCR64_SEED;
      laneData_reg   <= '0;
      laneK_reg      <= '0;
      hdr_reg        <= '0;
      fec_reg        <= 1'b0;
      up_reg         <= 1'b0;
      nco_reg        <= 1'b0;
    end else if (enable) begin
      syncPrev_reg   <= syncPrev_next;
      sysrefPrev_reg <= sysrefPrev_next;
      mfCnt_reg      <= mfCnt_next;
      state_reg      <= state_next;
      ilasCnt_reg    <= ilasCnt_next;
      scr8_reg       <= scr8_next;
      scr64_reg      <= scr64_next;
      laneData_reg   <= laneData_next;
      laneK_reg      <= laneK_next;
      hdr_reg        <= hdr_next;
      fec_reg        <= fec_next;
      up_reg         <= up_next;
      nco_reg        <= nco_next;
    end
  end

  assign laneData    = laneData_reg;
  assign laneCharK   = laneK_reg;
  assign laneSyncHdr = hdr_reg;
  assign laneFecOn   = fec_reg;
  assign linkUp      = up_reg;
  assign ncoSync     = nco_reg;

  // Checks on the design's own behaviour
  property p_comma_in_cgs;
    (enable && state_reg == ST_CGS) |=> (laneData == {LANES{CHAR_K28_5}} || !enable);
  endproperty
  a_comma_in_cgs: assert property (p_comma_in_cgs)
    else $error("No comma during CGS");

  property p_sysref_resets;
    (enable && sysrefRise) |=> (mfCnt_reg == '0);
  endproperty
  a_sysref_resets: assert property (p_sysref_resets)
    else $error("SYSREF did not reset counter");

  // Once running in block mode a low sync pin must never pull the link back
  property p_64_no_handshake;
    (codeMode == CODE_64B66B && $past(codeMode) == CODE_64B66B && $past(linkEnable)
      && $past(state_reg) == ST_RUN) |-> state_reg == ST_RUN;
  endproperty
  a_64_no_handshake: assert property (p_64_no_handshake)
    else $error("Handshake in 64B66B");

  property p_sync_rise_wait;
    (enable && linkEnable && state_reg == ST_CGS && syncLvl && !syncPrev_reg)
      |=> state_reg == ST_WAIT;
  endproperty
  a_sync_rise_wait: assert property (p_sync_rise_wait)
    else $error("No wait after sync rise");

  property p_hdr_64;
    (enable && codeMode == CODE_64B66B && $past(codeMode) == CODE_64B66B && $past(enable))
      |=> laneSyncHdr == SYNC_HDR_DATA || !enable;
  endproperty
  a_hdr_64: assert property (p_hdr_64)
    else $error("Missing sync header");

  property p_fec_only_64;
    laneFecOn |-> $past(codeMode) == CODE_64B66B;
  endproperty
  a_fec_only_64: assert property (p_fec_only_64)
    else $error("FEC outside 64B66B");

  property p_plain_8b;
    (enable && sendData && codeMode == CODE_8B10B && !scrambleEnable)
      |=> laneData == $past(fifoData) || !enable;
  endproperty
  a_plain_8b: assert property (p_plain_8b)
    else $error("Unrequested scrambling");

  property p_low_sync_restart;
    (enable && linkEnable && state_reg == ST_RUN && codeMode == CODE_8B10B && !syncLvl)
      |=> state_reg == ST_CGS;
  endproperty
  a_low_sync_restart: assert property (p_low_sync_restart)
    else $error("Low sync ignored");

  // Main scenarios: comma phase, alignment into data, block mode, full buffer
  c_cgs:  cover property (state_reg == ST_CGS);
  c_ilas: cover property (state_reg == ST_WAIT ##1 state_reg == ST_RUN);
  c_64:   cover property (codeMode == CODE_64B66B && sendData);
  c_full: cover property (!sampleReady);
endmodule

// [core/jtl_pkg.sv]
// Package for the transmit link interface: modes, characters, timing counts.
// Assumes a single 250 MHz device clock for all link logic.
package jtl_pkg;
  localparam int          LANE_MAX     = 8;        // Most serial lanes
  localparam int          OCTET_W      = 8;
  localparam int          FIFO_DEPTH   = 8;        // Sample buffer entries
  localparam int          FIFO_W       = 64;       // One octet per lane
  localparam int          ILAS_MF      = 4;        // Alignment multiframes
  localparam int          MF_LEN_W     = 10;       // Width of frames-per-multiframe count
  localparam logic [9:0]  MF_LEN_RST   = 10'h020;  // Default octet-clocks per multiframe
  localparam logic [7:0]  CHAR_K28_5   = 8'hbc;    // Comma
  localparam logic [7:0]  CHAR_K28_0   = 8'h1c;    // Multiframe start in alignment
  localparam logic [7:0]  CHAR_K28_3   = 8'h7c;    // Multiframe end in alignment
  localparam logic [1:0]  SYNC_HDR_DATA = 2'h1;    // Block header for data blocks
  localparam logic [14:0] SCR8_SEED    = 15'h7fff;
  localparam logic [57:0] SCR64_SEED   = 58'h3ffffffffffffff;
  localparam int          CLK_PERIOD_NS = 4;

  typedef enum logic [0:0] {
    CODE_8B10B  = 1'b0,
    CODE_64B66B = 1'b1
  } jtl_code_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CGS  = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_RUN  = 4'b1000
  } jtl_state_t;
endpackage

// [core/jtl_fifo.sv]
// Sample buffer between the converter data path and the link framer.
// Assumes both sides on the same clock; flip-flop storage addressed by index.
`timescale 1ns/1ns
module jtl_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0]      count_reg, count_next;
  logic             doWr, doRd;

  // Pointer and fill count update; full and empty come from the count
  always_comb begin
    doWr       = inValid && inReady;
    doRd       = outValid && outReady;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (doWr) begin
      wrPtr_next = (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
    end
    if (doRd) begin
      rdPtr_next = (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
    end
    if (doWr && !doRd) begin
      count_next = count_reg + 1'b1;
    end else if (doRd && !doWr) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (enable) begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      if (doWr) begin
        mem_reg[wrPtr_reg] <= inData;
      end
    end
  end

  // Ready and valid gated by enable so nothing moves while frozen
  assign inReady  = enable && (count_reg != (AW+1)'(DEPTH));
  assign outValid = enable && (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];
endmodule

// [core/jtl_sync_in.sv]
// Two-stage synchroniser for the sync request pin and the SYSREF pin.
// Assumes the pins are asynchronous to the device clock.
`timescale 1ns/1ns
module jtl_sync_in #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Reset to high: an idle sync request pin is high
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else if (enable) begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
    end
  end
  assign syncOut = sync_reg;
endmodule

// [verif/jtl_rx_model.sv]
// Receiver model at the far end of the lanes: drives the active-low sync pin.
// Assumes the bench pulses sysrefPin into this model and the device alike.
`timescale 1ns/1ns
module jtl_rx_model
  import jtl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        requestLink,
  input  wire logic        holdLow,
  input  wire logic [9:0]  mfLen,
  input  wire logic        sysrefPin,
  input  wire logic [63:0] laneData,
  input  wire logic [7:0]  laneCharK,
  output logic             syncPin
);
  logic [9:0] mfCnt_reg;
  logic [2:0] commaCnt_reg;
  logic       sysrefOld_reg;
  logic       lowReq_reg;
  logic       relDone_reg;

  // Local multiframe count, realigned by a SYSREF rising edge like the device's
  always_ff @(posedge clock) begin
    sysrefOld_reg <= sysrefPin;
    if (!reset_n || (sysrefPin && !sysrefOld_reg) || mfCnt_reg == mfLen - 10'h001) begin
      mfCnt_reg <= 10'h000;
    end else begin
      mfCnt_reg <= mfCnt_reg + 10'h001;
    end
  end

  // Request low, count commas on lane 0, release only on a multiframe edge
  always_ff @(posedge clock) begin
    if (!reset_n || !requestLink) begin
      lowReq_reg   <= 1'b0;
      relDone_reg  <= 1'b0;
      commaCnt_reg <= 3'h0;
    end else if (lowReq_reg && commaCnt_reg == 3'h4 && mfCnt_reg == 10'h000) begin
      lowReq_reg  <= 1'b0;
      relDone_reg <= 1'b1;
    end else begin
      lowReq_reg <= !relDone_reg;
      if (laneData[7:0] != CHAR_K28_5 || !laneCharK[0]) begin
        commaCnt_reg <= 3'h0;
      end else if (commaCnt_reg != 3'h4) begin
        commaCnt_reg <= commaCnt_reg + 3'h1;
      end
    end
  end

  // Pulled-up line: high unless a request or a commanded fault holds it low
  assign syncPin = !(lowReq_reg || holdLow);
endmodule

// [verif/jesd204c_tx_link_interface_test.sv]
// Self-checking bench for the transmit link, with a receiver model on the lanes.
// Assumes the package constants and a 250 MHz device clock.
`timescale 1ns/1ns
module jesd204c_tx_link_interface_test;
  import jtl_pkg::*;
  localparam int MF = 16;  // Short multiframe keeps the run brief
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        enable = 1'b1;
  logic        linkEnable = 1'b0;
  jtl_code_t   codeMode = CODE_8B10B;
  logic        scrambleEnable = 1'b0;
  logic        fecEnable = 1'b0;
  logic        syncForNco = 1'b0;
  logic        syncPin;
  logic        sysrefPin = 1'b0;
  logic [63:0] sampleData = 64'h0;
  logic        sampleValid = 1'b0;
  logic        sampleReady;
  logic [63:0] laneData;
  logic [7:0]  laneCharK;
  logic [1:0]  laneSyncHdr;
  logic        laneFecOn;
  logic        linkUp;
  logic        ncoSync;
  logic        requestLink = 1'b0;
  logic        holdLow = 1'b0;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          phase[2];

  // Clock and a cycle count for timing measurements
  always #(CLK_PERIOD_NS / 2) clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  jtl_tx_link i_dut (.clock(clock), .reset_n(reset_n), .enable(enable),
    .linkEnable(linkEnable), .codeMode(codeMode), .scrambleEnable(scrambleEnable),
    .fecEnable(fecEnable), .syncForNco(syncForNco), .multiframeLen(10'(MF)),
    .sync_request_input_pin(syncPin), .sysrefPin(sysrefPin), .sampleData(sampleData),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .laneData(laneData),
    .laneCharK(laneCharK), .laneSyncHdr(laneSyncHdr), .laneFecOn(laneFecOn),
    .linkUp(linkUp), .ncoSync(ncoSync));

  jtl_rx_model i_rx (.clock(clock), .reset_n(reset_n), .requestLink(requestLink),
    .holdLow(holdLow), .mfLen(10'(MF)), .sysrefPin(sysrefPin), .laneData(laneData),
    .laneCharK(laneCharK), .syncPin(syncPin));

  // Distinct non-zero sample words
  function automatic logic [63:0] word(input int i);
    return 64'ha5c3_0000_0000_0000 | 64'(i + 1);
  endfunction

  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // A used-up bound ends the run at once
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("CHECK FAILED t=%0t wait timed out", $time);
      wrap_up();
    end
  endtask

  // Fill the buffer while the link is idle, so the far side effectively stalls
  task automatic t_fill();
    int got;
    got = 0;
    enable = 1'b0;
    @(negedge clock);
    chk(sampleReady === 1'b0, "ready while frozen");
    enable = 1'b1;
    @(negedge clock);
    sampleValid = 1'b1;
    for (int i = 0; i < 12; i++) begin
      sampleData = word(got);
      got += (sampleReady === 1'b1);
      @(negedge clock);
    end
    sampleValid = 1'b0;
    chk(got == FIFO_DEPTH && sampleReady === 1'b0, "buffer depth wrong");
  endtask

  // Character mode: SYSREF, comma phase, alignment, data, then a restart
  task automatic t_link8(input int run, input logic scr);
    int n;
    int tSys;
    int tRel;
    @(negedge clock);
    codeMode = CODE_8B10B;
    scrambleEnable = scr;
    fecEnable = 1'b1;
    repeat (3 + 5 * run) @(negedge clock);
    sysrefPin = 1'b1;
    tSys = cyc;
    repeat (2) @(negedge clock);
    sysrefPin = 1'b0;
    repeat (4) @(negedge clock);
    linkEnable = 1'b1;
    requestLink = 1'b1;
    for (n = 0; n < 40 && laneCharK !== 8'hff; n++) @(negedge clock);
    tmo(n, 40);
    chk(laneData === {LANE_MAX{CHAR_K28_5}}, "commas missing");
    chk(linkUp === 1'b0 && laneSyncHdr === 2'h0, "early link");
    chk(laneFecOn === 1'b0, "correction flagged in character mode");
    for (n = 0; n < 400 && syncPin !== 1'b1; n++) @(negedge clock);
    tmo(n, 400);
    tRel = cyc;
    for (n = 0; n < 100 && !(laneData[7:0] === CHAR_K28_0 && laneCharK[0]); n++)
      @(negedge clock);
    tmo(n, 100);
    phase[run] = (cyc - tSys) % MF;
    for (n = 0; n < 200 && linkUp !== 1'b1; n++) @(negedge clock);
    tmo(n, 200);
    chk(cyc - tRel >= 4 * MF && cyc - tRel <= 5 * MF + 8, "alignment length");
    if (!scr) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        for (n = 0; n < 12 && laneData !== word(i); n++) @(negedge clock);
        chk(n < 12 && laneCharK === 8'h00, "buffered word lost");
      end
    end else begin
      // A zero word must leave the lanes scrambled once scrambling is requested
      sampleData = 64'h0;
      sampleValid = 1'b1;
      @(negedge clock);
      sampleValid = 1'b0;
      for (n = 0; n < 8 && laneData === 64'h0; n++) @(negedge clock);
      chk(n < 8 && laneCharK === 8'h00, "requested scrambling missing");
    end
    holdLow = 1'b1;
    repeat (2) begin
      @(negedge clock);
      chk(linkUp === 1'b1, "sync pin seen unsynchronised");
    end
    for (n = 0; n < 8 && laneCharK !== 8'hff; n++) @(negedge clock);
    chk(n < 8 && laneData === {LANE_MAX{CHAR_K28_5}}, "no restart");
    holdLow = 1'b0;
    linkEnable = 1'b0;
    requestLink = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  // Block mode: header, correction flag, scrambling, sync pin only for the NCO
  task automatic t_link64();
    int n;
    @(negedge clock);
    codeMode = CODE_64B66B;
    syncForNco = 1'b1;
    linkEnable = 1'b1;
    for (n = 0; n < 4 && linkUp !== 1'b1; n++) @(negedge clock);
    tmo(n, 4);
    chk(laneSyncHdr === SYNC_HDR_DATA, "block header");
    chk(laneFecOn === 1'b1, "correction flag");
    // An all-zero block only turns non-zero on the lanes through the scrambler
    sampleData = 64'h0;
    sampleValid = 1'b1;
    @(negedge clock);
    sampleValid = 1'b0;
    for (n = 0; n < 8 && laneData === 64'h0; n++) @(negedge clock);
    chk(n < 8, "zero block sent unscrambled");
    holdLow = 1'b1;
    repeat (5) @(negedge clock);
    chk(linkUp === 1'b1 && ncoSync === 1'b1, "sync pin misused");
    holdLow = 1'b0;
    repeat (5) @(negedge clock);
    chk(ncoSync === 1'b0, "oscillator sync stuck");
    linkEnable = 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(negedge clock);
    chk(laneData === 64'h0 && linkUp === 1'b0, "outputs not cleared in reset");
    reset_n = 1'b1;
    t_fill();
    t_link8(0, 1'b0);
    t_link8(1, 1'b1);
    chk(phase[0] == phase[1], "multiframe phase not tied to SYSREF");
    t_link64();
    wrap_up();
  end
endmodule
